/* File: verilog/pll_reference_and_feedback_divider.sv */
// What this block does
// - source bit: 0 crystal, 1 external
// - doubler bit doubles reference, else bypass
// - ten bit reference counter, 1..1023
// - ratio one bypasses reference counter
// - halving bit adds divide-by-two stage
// - comparison rate follows doubler/ratio/halving formula
// - VCO equals comparison times N
// - feedback divides VCO by INT+FRAC/DEN
// - integer sixteen bits, 75..65535 valid
// - fraction, denominator twenty-four bits each
// - zero fraction means integer-N mode
// - detector compares reference and feedback edges
// - fixed delay gives minimum pulse widths
// - four bit pump code, (code+1)*312.5uA
// - pump code resets to three
// - N values at 0x200..0x20A
// - pump code register at 0x22E
// - integer low write applies, starts calibration
`include "pll_div_cfg.svh"
module pll_reference_and_feedback_divider #(
    parameter int DELAY_CYC = `PFD_DELAY_CYC
) (
    input  wire logic        hclk,          // bus and logic clock
    input  wire logic        hresetn,       // async reset, active low
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write when high
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic        hready,        // bus ready in
    input  wire logic [31:0] hwdata,        // write data
    output logic      [31:0] hrdata,        // read data
    output logic             hreadyout,     // always ready
    output logic             hresp,         // always okay
    input  wire logic        xtal_clk_in,   // crystal reference pin
    input  wire logic        ext_ref_in,    // single-ended reference pin
    input  wire logic        vco_fb_in,     // divided VCO feedback pin
    output logic             pump_up,       // charge pump up
    output logic             pump_down,     // charge pump down
    output logic [3:0]       pump_current_code, // pump current setting
    output logic             ref_div_out,   // comparison-rate reference
    output logic             fb_div_out,    // comparison-rate feedback
    output logic             autocal_start  // one-cycle calibration kick
);
    // staged (software visible) and active N settings
    logic [15:0] int_stage, int_act;
    logic [23:0] frac_stage, frac_act, den_stage, den_act;
    logic [9:0]  ref_div_ratio;
    logic [7:0]  ref_path_config;
    logic        int_invalid;
    // declared early: the read mux and synchronisers use them first
    logic        ref_sel;
    logic        frac_mode;
    logic        pfd_busy;

    // bus address phase capture
    logic        dp_write, dp_read;
    logic [11:0] dp_idx;
    wire         addr_ok   = hsel && hready && htrans[1];
    wire  [11:0] addr_idx  = haddr[13:2];
    wire  [7:0]  wbyte     = hwdata[7:0];
    wire         wr_int_lo = dp_write && dp_idx == `IDX_INT_LOW;

    function automatic logic wr_at(input logic [11:0] idx);
        wr_at = dp_write && dp_idx == idx;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_idx   <= 12'h000;
        end else begin
            dp_write <= addr_ok && hwrite;
            dp_read  <= addr_ok && !hwrite;
            dp_idx   <= addr_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stage         <= `RST_INT;
            frac_stage        <= `RST_FRAC;
            den_stage         <= `RST_DEN;
            ref_div_ratio     <= `RST_REF_DIV;
            ref_path_config   <= `RST_REF_PATH;
            pump_current_code <= `RST_PUMP_CODE;
        end else begin
            if (wr_at(`IDX_INT_LOW))       int_stage[7:0]    <= wbyte;
            if (wr_at(`IDX_INT_HIGH))      int_stage[15:8]   <= wbyte;
            if (wr_at(`IDX_FRAC_LOW))      frac_stage[7:0]   <= wbyte;
            if (wr_at(`IDX_FRAC_MID))      frac_stage[15:8]  <= wbyte;
            if (wr_at(`IDX_FRAC_HIGH))     frac_stage[23:16] <= wbyte;
            if (wr_at(`IDX_DEN_LOW))       den_stage[7:0]    <= wbyte;
            if (wr_at(`IDX_DEN_MID))       den_stage[15:8]   <= wbyte;
            if (wr_at(`IDX_DEN_HIGH))      den_stage[23:16]  <= wbyte;
            if (wr_at(`IDX_REF_DIV_LOW))   ref_div_ratio[7:0] <= wbyte;
            if (wr_at(`IDX_REF_DIV_HIGH))  ref_div_ratio[9:8] <= hwdata[1:0];
            if (wr_at(`IDX_REF_PATH))      ref_path_config   <= {5'h00, hwdata[2:0]};
            if (wr_at(`IDX_PUMP_CURRENT))  pump_current_code <= hwdata[3:0];
        end
    end

    // double-buffered apply on integer low write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_act       <= `RST_INT;
            frac_act      <= `RST_FRAC;
            den_act       <= `RST_DEN;
            autocal_start <= 1'b0;
        end else begin
            autocal_start <= wr_int_lo;
            if (wr_int_lo) begin
                int_act  <= {int_stage[15:8], wbyte};
                frac_act <= frac_stage;
                den_act  <= (den_stage == 24'h000000) ? 24'h000001 : den_stage;
            end
        end
    end

    assign int_invalid = int_act < `INT_MIN;

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        unique case (dp_idx)
            `IDX_INT_LOW:      rd_mux = {24'h000000, int_stage[7:0]};
            `IDX_INT_HIGH:     rd_mux = {24'h000000, int_stage[15:8]};
            `IDX_FRAC_LOW:     rd_mux = {24'h000000, frac_stage[7:0]};
            `IDX_FRAC_MID:     rd_mux = {24'h000000, frac_stage[15:8]};
            `IDX_FRAC_HIGH:    rd_mux = {24'h000000, frac_stage[23:16]};
            `IDX_DEN_LOW:      rd_mux = {24'h000000, den_stage[7:0]};
            `IDX_DEN_MID:      rd_mux = {24'h000000, den_stage[15:8]};
            `IDX_DEN_HIGH:     rd_mux = {24'h000000, den_stage[23:16]};
            `IDX_REF_DIV_LOW:  rd_mux = {24'h000000, ref_div_ratio[7:0]};
            `IDX_REF_DIV_HIGH: rd_mux = {30'h0000000, ref_div_ratio[9:8]};
            `IDX_REF_PATH:     rd_mux = {24'h000000, ref_path_config};
            `IDX_PUMP_CURRENT: rd_mux = {28'h0000000, pump_current_code};
            `IDX_STATUS:       rd_mux = {29'h0000000, int_invalid, frac_mode, pfd_busy};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // read data valid in the data phase; no wait states
    assign hrdata    = dp_read ? rd_mux : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // pin synchronisers
    logic [1:0] xtal_sync, ext_sync, fb_sync;
    logic       ref_q, fb_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xtal_sync <= 2'b00;
            ext_sync  <= 2'b00;
            fb_sync   <= 2'b00;
            ref_q     <= 1'b0;
            fb_q      <= 1'b0;
        end else begin
            xtal_sync <= {xtal_sync[0], xtal_clk_in};
            ext_sync  <= {ext_sync[0], ext_ref_in};
            fb_sync   <= {fb_sync[0], vco_fb_in};
            ref_q     <= ref_sel;
            fb_q      <= fb_sync[1];
        end
    end

    // source switch is not glitch free: a change may add one stray edge
    assign ref_sel = ref_path_config[`BIT_SRC_SEL] ? ext_sync[1] : xtal_sync[1];
    wire ref_rise = ref_sel && !ref_q;
    // doubler: both edges count as reference events
    wire ref_edge = ref_path_config[`BIT_DOUBLER] ? (ref_sel ^ ref_q) : ref_rise;
    wire fb_rise  = fb_sync[1] && !fb_q;

    // reference counter then optional halver
    logic [9:0] ref_count;
    logic       half_phase;
    wire        div_one  = ref_div_ratio <= 10'h001;
    wire        rc_pulse = ref_edge && (div_one || ref_count == ref_div_ratio - 10'h001);
    wire        ref_tick = rc_pulse && (!ref_path_config[`BIT_HALF_SEL] || half_phase);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_count  <= 10'h000;
            half_phase <= 1'b0;
        end else begin
            if (rc_pulse)
                ref_count <= 10'h000;
            else if (ref_edge)
                ref_count <= ref_count + 10'h001;
            if (rc_pulse)
                half_phase <= !half_phase;
        end
    end

    // fractional feedback divider
    logic [15:0] fb_count;
    logic [23:0] accum;
    logic        extra;
    assign frac_mode = frac_act != 24'h000000;
    wire  [24:0] acc_sum   = {1'b0, accum} + {1'b0, frac_act};
    wire         acc_ovf   = acc_sum >= {1'b0, den_act};
    wire  [15:0] fb_limit  = extra ? int_act : int_act - 16'h0001;
    wire         fb_tick   = fb_rise && fb_count >= fb_limit;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_count <= 16'h0000;
            accum    <= 24'h000000;
            extra    <= 1'b0;
        end else if (wr_int_lo) begin
            fb_count <= 16'h0000;
            accum    <= 24'h000000;
            extra    <= 1'b0;
        end else if (fb_tick) begin
            fb_count <= 16'h0000;
            if (frac_mode) begin
                accum <= acc_ovf ? 24'(acc_sum - {1'b0, den_act}) : acc_sum[23:0];
                extra <= acc_ovf;
            end else begin
                accum <= 24'h000000;
                extra <= 1'b0;
            end
        end else if (fb_rise) begin
            fb_count <= fb_count + 16'h0001;
        end
    end

    // phase-frequency detector with fixed reset delay
    pll_div_pkg::pfd_state_type pfd_state, next_pfd_state;
    logic [7:0] delay_count;
    wire        delay_done = delay_count >= 8'(DELAY_CYC - 1);
    assign pfd_busy = pfd_state != pll_div_pkg::PFD_IDLE;
    always_comb begin
        next_pfd_state = pfd_state;
        unique case (pfd_state)
            pll_div_pkg::PFD_IDLE:
                if (ref_tick && fb_tick) next_pfd_state = pll_div_pkg::PFD_RESET;
                else if (ref_tick)       next_pfd_state = pll_div_pkg::PFD_UP;
                else if (fb_tick)        next_pfd_state = pll_div_pkg::PFD_DOWN;
            pll_div_pkg::PFD_UP:
                if (fb_tick) next_pfd_state = pll_div_pkg::PFD_RESET;
            pll_div_pkg::PFD_DOWN:
                if (ref_tick) next_pfd_state = pll_div_pkg::PFD_RESET;
            pll_div_pkg::PFD_RESET:
                if (delay_done) next_pfd_state = pll_div_pkg::PFD_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pfd_state   <= pll_div_pkg::PFD_IDLE;
            delay_count <= 8'h00;
            pump_up     <= 1'b0;
            pump_down   <= 1'b0;
            ref_div_out <= 1'b0;
            fb_div_out  <= 1'b0;
        end else begin
            pfd_state   <= next_pfd_state;
            delay_count <= (pfd_state == pll_div_pkg::PFD_RESET) ? delay_count + 8'h01 : 8'h00;
            // both pumps on while the reset delay runs: no dead zone
            pump_up     <= next_pfd_state == pll_div_pkg::PFD_UP
                        || next_pfd_state == pll_div_pkg::PFD_RESET;
            pump_down   <= next_pfd_state == pll_div_pkg::PFD_DOWN
                        || next_pfd_state == pll_div_pkg::PFD_RESET;
            ref_div_out <= ref_tick;
            fb_div_out  <= fb_tick;
        end
    end

    a_pump_reset_val: assert property (@(posedge hclk) $rose(hresetn)
        |-> pump_current_code == `RST_PUMP_CODE) else $error("pump code not three");
    a_apply_on_intlo: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_int_lo |=> autocal_start && int_act[7:0] == $past(wbyte)) else $error("apply lost");
    a_stage_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_int_lo |=> $stable(int_act) && $stable(frac_act)) else $error("early apply");
    a_both_pumps_min: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pump_up && pump_down) |-> (pump_up && pump_down) [*2]) else $error("no overlap");
    a_no_extra_int: assert property (@(posedge hclk) disable iff (!hresetn)
        !frac_mode && fb_tick |=> !extra) else $error("extra in integer mode");
    a_bypass_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        div_one && ref_edge |-> rc_pulse) else $error("bypass failed");
    a_up_on_ref: assert property (@(posedge hclk) disable iff (!hresetn)
        pfd_state == pll_div_pkg::PFD_IDLE && ref_tick && !fb_tick |=> pump_up && !pump_down)
        else $error("up missing");
    a_half_skip: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_path_config[`BIT_HALF_SEL] && rc_pulse && !half_phase |-> !ref_tick)
        else $error("halver failed");

    // detector outputs mirror the current state, registered on the same edge
    a_pump_up_state: assert property (@(posedge hclk) disable iff (!hresetn)
        pump_up == (pfd_state == pll_div_pkg::PFD_UP || pfd_state == pll_div_pkg::PFD_RESET))
        else $error("up not from state");
    a_pump_dn_state: assert property (@(posedge hclk) disable iff (!hresetn)
        pump_down == (pfd_state == pll_div_pkg::PFD_DOWN || pfd_state == pll_div_pkg::PFD_RESET))
        else $error("down not from state");
    a_reset_len: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pfd_state == pll_div_pkg::PFD_RESET) |-> (pfd_state == pll_div_pkg::PFD_RESET) [*2]
        ##1 pfd_state == pll_div_pkg::PFD_IDLE) else $error("reset window length");
    a_down_on_fb: assert property (@(posedge hclk) disable iff (!hresetn)
        pfd_state == pll_div_pkg::PFD_IDLE && fb_tick && !ref_tick |=> pump_down && !pump_up)
        else $error("down missing");
    a_both_to_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        pfd_state == pll_div_pkg::PFD_IDLE && ref_tick && fb_tick
        |=> pfd_state == pll_div_pkg::PFD_RESET) else $error("coincident ticks");
    a_up_to_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        pfd_state == pll_div_pkg::PFD_UP && fb_tick |=> pfd_state == pll_div_pkg::PFD_RESET)
        else $error("up not cleared");

    // apply restarts the feedback divider from a clean phase
    a_accum_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_int_lo |=> accum == 24'h000000 && !extra && fb_count == 16'h0000)
        else $error("divider not restarted");
    a_accum_below: assert property (@(posedge hclk) disable iff (!hresetn)
        frac_mode && fb_tick && !wr_int_lo && accum < den_act && frac_act < den_act
        |=> accum < den_act) else $error("accumulator overrun");
    a_ovf_extra: assert property (@(posedge hclk) disable iff (!hresetn)
        frac_mode && fb_tick && acc_ovf && !wr_int_lo |=> extra)
        else $error("overflow lost");
    a_den_nonzero: assert property (@(posedge hclk) disable iff (!hresetn)
        den_act != 24'h000000) else $error("zero denominator");

    // reference path counting
    a_ref_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        rc_pulse |=> ref_count == 10'h000) else $error("counter not restarted");
    a_ref_step: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_edge && !rc_pulse |=> ref_count == $past(ref_count) + 10'h001)
        else $error("counter step");
    a_half_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_path_config[`BIT_HALF_SEL] && rc_pulse && half_phase |-> ref_tick)
        else $error("halver lost tick");
    a_half_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !ref_path_config[`BIT_HALF_SEL] && rc_pulse |-> ref_tick)
        else $error("bypass lost tick");
    a_ref_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ref_tick |=> ref_div_out) else $error("ref pulse missing");
    a_fb_out: assert property (@(posedge hclk) disable iff (!hresetn)
        fb_tick |=> fb_div_out) else $error("fb pulse missing");
    a_code_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        !(dp_write && dp_idx == `IDX_PUMP_CURRENT) |=> $stable(pump_current_code))
        else $error("pump code changed");
endmodule // pll_reference_and_feedback_divider

/* File: inc/pll_div_cfg.svh */
`ifndef PLL_DIV_CFG_SVH
`define PLL_DIV_CFG_SVH
// register indices (printed offsets, byte address = 4 * index)
`define IDX_INT_LOW        12'h200
`define IDX_INT_HIGH       12'h201
`define IDX_FRAC_LOW       12'h202
`define IDX_FRAC_MID       12'h203
`define IDX_FRAC_HIGH      12'h204
`define IDX_DEN_LOW        12'h208
`define IDX_DEN_MID        12'h209
`define IDX_DEN_HIGH       12'h20A
`define IDX_REF_DIV_LOW    12'h20C
`define IDX_REF_DIV_HIGH   12'h20D
`define IDX_REF_PATH       12'h20E
`define IDX_PUMP_CURRENT   12'h22E
`define IDX_STATUS         12'h230
// field positions in ref_path_config
`define BIT_HALF_SEL       0
`define BIT_SRC_SEL        1
`define BIT_DOUBLER        2
// reset values
`define RST_INT            16'h00A7
`define RST_FRAC           24'h000002
`define RST_DEN            24'h000003
`define RST_REF_DIV        10'h001
`define RST_REF_PATH       8'h00
`define RST_PUMP_CODE      4'h3
// timing and integer limit
`define PFD_DELAY_NS       40
`define CLK_PERIOD_NS      20
`define PFD_DELAY_CYC      ((`PFD_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_MIN            16'h004B
`endif

/* File: inc/pll_div_pkg.sv */
package pll_div_pkg;
    typedef enum logic [1:0] {
        PFD_IDLE  = 2'b00,
        PFD_UP    = 2'b01,
        PFD_RESET = 2'b11,
        PFD_DOWN  = 2'b10
    } pfd_state_type;
endpackage

/* File: verif/pll_osc_model.sv */
module pll_osc_model (
    input  wire logic vco_slow, // stretch the feedback period
    output logic      xtal_clk, // crystal oscillator, period 200 ns
    output logic      ext_ref,  // single-ended source, period 280 ns
    output logic      vco_fb    // prescaled vco, period 120 or 200 ns
);
    timeunit 1ns;
    timeprecision 1ps;
    // oscillators run free; edges fall on hclk falling edges, never on rising ones, so counts are exact
    initial begin
        xtal_clk = 1'b0;
        ext_ref = 1'b0;
        vco_fb = 1'b0;
    end
    always #100 xtal_clk = ~xtal_clk;
    always #140 ext_ref = ~ext_ref;
    always #(vco_slow ? 100 : 60) vco_fb = ~vco_fb;
endmodule // pll_osc_model

/* File: verif/pll_reference_and_feedback_divider_tb.sv */
`include "pll_div_cfg.svh"
module pll_reference_and_feedback_divider_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        vco_slow = 1'b0;
    wire  [31:0] hrdata;
    wire  [3:0]  pump_current_code;
    wire         hreadyout, hresp, xtal_clk, ext_ref, vco_fb;
    wire         pump_up, pump_down, ref_div_out, fb_div_out, autocal_start;
    int          n_errors = 0;
    int          num_checks = 0;
    logic [31:0] seed = 32'hC17F;
    int          regs [int];

    pll_osc_model osc (.vco_slow(vco_slow), .xtal_clk(xtal_clk), .ext_ref(ext_ref),
        .vco_fb(vco_fb));
    pll_reference_and_feedback_divider uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .xtal_clk_in(xtal_clk), .ext_ref_in(ext_ref), .vco_fb_in(vco_fb),
        .pump_up(pump_up), .pump_down(pump_down), .pump_current_code(pump_current_code),
        .ref_div_out(ref_div_out), .fb_div_out(fb_div_out), .autocal_start(autocal_start));

    always #10 hclk = ~hclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic test_done;
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
        regs[idx] = d;
    endtask
    task automatic rdc(input logic [11:0] idx);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0, x);
        chk(x, regs.exists(idx) ? 32'(regs[idx]) : 32'h0);
    endtask
    task automatic apply(input int n_int);
        wr(`IDX_INT_HIGH, 32'(n_int >> 8));
        @(posedge hclk);
        chk({31'h0, autocal_start}, 32'h0);
        wr(`IDX_INT_LOW, 32'(n_int & 255));
        @(posedge hclk);
        chk({31'h0, autocal_start}, 32'h1);
        @(posedge hclk);
        chk({31'h0, autocal_start}, 32'h0);
    endtask
    task automatic prog(input int n_int, input int frac, input int den);
        wr(`IDX_FRAC_HIGH, 32'(frac >> 16));
        wr(`IDX_FRAC_MID, 32'((frac >> 8) & 255));
        wr(`IDX_FRAC_LOW, 32'(frac & 255));
        wr(`IDX_DEN_HIGH, 32'(den >> 16));
        wr(`IDX_DEN_MID, 32'((den >> 8) & 255));
        wr(`IDX_DEN_LOW, 32'(den & 255));
        apply(n_int);
    endtask
    task automatic refcfg(input int r, input int src, input int dbl, input int half);
        wr(`IDX_REF_DIV_LOW, 32'(r & 255));
        wr(`IDX_REF_DIV_HIGH, 32'(r >> 8));
        wr(`IDX_REF_PATH, 32'(dbl * 4 + src * 2 + half));
        apply(167);
    endtask
    // skips the first pulse, since it may belong to the old setting
    task automatic span(input logic fb, input int n, output int cyc);
        int k;
        k = 0;
        cyc = 0;
        repeat (2) do @(posedge hclk); while ((fb ? fb_div_out : ref_div_out) !== 1'b1);
        while (k < n) begin
            @(posedge hclk);
            cyc++;
            if ((fb ? fb_div_out : ref_div_out) === 1'b1) k++;
        end
    endtask
    task automatic phase_frequency_detector(output int up, output int dn, output int both, output int rmin);
        int run;
        {up, dn, both, run, rmin} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1000};
        repeat (12000) begin
            @(posedge hclk);
            up += int'(pump_up === 1'b1);
            dn += int'(pump_down === 1'b1);
            both += int'(pump_up === 1'b1 && pump_down === 1'b1);
            if (pump_up === 1'b1) run++;
            else if (run > 0) begin
                rmin = (run < rmin) ? run : rmin;
                run = 0;
            end
        end
    endtask

    initial begin
        repeat (100000) @(posedge hclk);
        n_errors++;
        test_done;
    end

    initial begin
        int c, r, up, dn, both, rmin;
        logic [11:0] ridx [3];
        ridx = '{`IDX_REF_DIV_LOW, `IDX_FRAC_MID, `IDX_DEN_HIGH};
        regs[`IDX_PUMP_CURRENT] = 3;
        regs[`IDX_INT_LOW] = 167;
        regs[`IDX_REF_DIV_LOW] = 1;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk({28'h0, pump_current_code}, 32'h3);
        rdc(`IDX_PUMP_CURRENT);
        rdc(`IDX_INT_LOW);
        rdc(`IDX_REF_DIV_LOW);
        rdc(12'h0F0);
        chk({31'h0, hresp}, 32'h0);
        span(1'b1, 3, c);
        chk(32'(c), 32'(6 * (167 * 3 + 2)));
        for (int i = 0; i < 16; i++) begin
            wr(`IDX_PUMP_CURRENT, 32'(i));
            rdc(`IDX_PUMP_CURRENT);
            chk({28'h0, pump_current_code}, 32'(i));
        end
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            wr(ridx[i], {24'h0, seed[7:0]});
            rdc(ridx[i]);
        end
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            r = (i < 2) ? 1 : (i == 8) ? 1023 : 2 + int'(seed % 6);
            refcfg(r, (i == 8) ? 0 : i % 2, (i == 8) ? 1 : (i / 2) % 2, (i / 4) % 2);
            span(1'b0, 3, c);
            chk(32'(c), 32'(3 * ((i % 2 && i < 8) ? 14 : 10) * r * (1 + (i / 4) % 2)
                / (1 + ((i == 8) ? 1 : (i / 2) % 2))));
        end
        prog(75, 0, 5);
        span(1'b1, 2, c);
        chk(32'(c), 32'(2 * 6 * 75));
        wr(`IDX_FRAC_LOW, 32'h1);
        span(1'b1, 2, c);
        chk(32'(c), 32'(2 * 6 * 75));
        vco_slow <= 1'b1;
        prog(75, 1, 300 / 100);
        span(1'b1, 3, c);
        chk(32'(c), 32'(10 * (75 * 3 + 1)));
        vco_slow <= 1'b0;
        wr(`IDX_PUMP_CURRENT, 32'(1250 * 50 / 100 * 10 / 3125 - 1));
        rdc(`IDX_PUMP_CURRENT);
        refcfg(1, 0, 0, 0);
        prog(75, 0, 1);
        phase_frequency_detector(up, dn, both, rmin);
        chk(32'(up > dn), 32'h1);
        chk(32'(both > 0), 32'h1);
        chk(32'(rmin >= `PFD_DELAY_CYC), 32'h1);
        refcfg(1023, 0, 1, 0);
        phase_frequency_detector(up, dn, both, rmin);
        chk(32'(dn > up), 32'h1);
        chk(32'(both > 0), 32'h1);
        test_done;
    end
endmodule // pll_reference_and_feedback_divider_tb
